// ===== pkg/idle_standby_defines.svh
`ifndef IDLE_STANDBY_DEFINES_SVH
`define IDLE_STANDBY_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define STBY_CTRL_OFS 8'h00
`define EDGE_ZERO_OFS 8'h04
`define EDGE_ONE_OFS 8'h08
`define IRQ_CFG_OFS 8'h0C
`define OSC_SETTLE_OFS 8'h10
`define ADC_MODE_OFS 8'h14
`define DAC_MODE_OFS 8'h18
`define PORT_LATCH_OFS 8'h1C
`define PORT_MODE_OFS 8'h20
`define PORT_CTRL_OFS 8'h24
`define STATUS_OFS 8'h28

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define MODE_RUN 2'h0
`define MODE_HALT 2'h1
`define MODE_STOP 2'h2
`define MODE_IDLE 2'h3
`define EXT_CLK_SEL_BIT 0
`define ADC_POWER_BIT 7
`define MASK_A_BIT 0
`define MASK_B_BIT 1
`define MACRO_A_BIT 2
`define MACRO_B_BIT 3

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define IRQ_CFG_RESET 4'h3
`define DAC_MODE_RESET 2'h3
`define PORT_MODE_RESET 8'hFF
`define REFRESH_FIXED_LEVEL 1'b1
`define CONTENTION_CLKS 6

`endif

// ===== pkg/idle_standby_pkg.sv
package idle_standby_pkg;

  // --------------------------------------------------------------------
  // Bus, core and pin carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic nmi_ack_ok;
    logic ext_ack_ok;
    logic irq_allow;
    logic nmi_taken;
    logic ext_taken;
    logic halt_release;
    logic refresh_hw;
    logic [7:0] port_hw_lvl;
    logic [7:0] port_hw_oe;
  } core_status_t;

  typedef struct packed {
    logic bus_oe;
    logic ale_oe;
    logic refresh_lvl;
    logic refresh_oe;
    logic [1:0] ano_oe;
    logic [1:0] ano_ref3;
    logic dac_power;
    logic adc_power;
    logic osc_run;
    logic [7:0] port_lvl;
    logic [7:0] port_oe;
  } pin_ctrl_t;

endpackage

// ===== hdl/pin_edge_sync.sv
module pin_edge_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  input wire logic rising_in,
  output logic edge_out
);

  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic edge_q;
  logic edge_d;

  always_comb begin
    edge_d = (sync_q != prev_q) && (sync_q == rising_in);
  end

  // The first stage feeds only the second; the edge is taken downstream.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      edge_q <= edge_d;
    end
  end

  assign edge_out = edge_q;

endmodule

// ===== hdl/idle_standby_wakeup.sv
`include "idle_standby_defines.svh"
// Operation
// RULE1: An NMI pin edge of the selected polarity ends IDLE.
// RULE2: After NMI wake, branch to the NMI handler when acknowledgeable.
// RULE3: Unacknowledgeable NMI wake resumes in line and stays pending for later.
// RULE4: Pin a or b edge ends IDLE only if unmasked and macro off.
// RULE5: Pin wake branches if global enable set and acknowledgeable, else resumes.
// RULE6: Address, data and strobe pins float in STOP or IDLE.
// RULE7: Latch strobe floats; refresh or hold pin fixed in STOP or IDLE.
// RULE8: Standby does not stop the D/A converter channels.
// RULE9: Both D/A bits clear floats outputs; one bit clear saves nothing.
// RULE10: Enabled D/A channel drives the third reference during standby.
// RULE11: Standby request with a release condition pending is refused.
// RULE12: External clock select bit set stops the resonator oscillator.
// RULE13: Software sets external clock select and feeds inverted clock.
// RULE14: Software puts three no-ops after every standby instruction.
// RULE15: A contending interrupt is taken within six clocks of standby write.
// RULE16: Software clears the converter power bit before STOP or IDLE.
// RULE17: Port mode pins follow latch and mode; control mode follows hardware.
// RULE18: Only NMI, pins a and b, and reset release IDLE.
// RULE19: A wake request not yet acknowledged stays held until taken.
// RULE20: Standby control register write latches the requested mode.
// RULE21: A masked or macro-serviced pin edge leaves IDLE in place.
module idle_standby_wakeup
  import idle_standby_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int CONT_CLKS = `CONTENTION_CLKS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire wb_req_t wb_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic nmi_pin_in,
  input wire logic ext_irq_pin_a_in,
  input wire logic ext_irq_pin_b_in,
  input wire core_status_t core_in,
  output logic [1:0] standby_state_out,
  output logic branch_nmi_out,
  output logic branch_ext_out,
  output logic resume_out,
  output pin_ctrl_t pins_out
);

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------
  generate
    if (PORT_W != 8) begin : g_bad_port
      $error("PORT_W must be 8 to match the core status carrier.");
    end
    if (CONT_CLKS < 1 || CONT_CLKS > 15) begin : g_bad_cont
      $error("CONT_CLKS must lie between 1 and 15.");
    end
  endgenerate

  typedef enum logic [2:0] {
    ST_RUN,
    ST_ENTER,
    ST_HALT,
    ST_STOP,
    ST_IDLE
  } state_t;

  function automatic logic is_deep(input state_t s);
    is_deep = (s == ST_STOP) || (s == ST_IDLE);
  endfunction

  // --------------------------------------------------------------------
  // Pin edge detection
  // --------------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] pin_rise;
  logic [2:0] pin_edge;
  logic edge_zero_q;
  logic [1:0] edge_one_q;

  assign pin_raw = {ext_irq_pin_b_in, ext_irq_pin_a_in, nmi_pin_in};
  assign pin_rise = {edge_one_q, edge_zero_q};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      pin_edge_sync u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(pin_raw[gi]),
        .rising_in(pin_rise[gi]),
        .edge_out(pin_edge[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  logic edge_zero_d;
  logic [1:0] edge_one_d;
  logic [3:0] irq_cfg_q, irq_cfg_d;
  logic [7:0] osc_q, osc_d;
  logic [7:0] adc_q, adc_d;
  logic [1:0] dac_q, dac_d;
  logic [7:0] latch_q, latch_d;
  logic [7:0] pmode_q, pmode_d;
  logic [7:0] pctrl_q, pctrl_d;
  logic [31:0] rdat_q, rdat_d;
  logic ack_q, ack_d;
  logic stby_wr;
  logic [1:0] stby_mode;
  logic nmi_pend_q;
  logic ext_pend_q;
  state_t state_q;

  logic access;
  logic wr_lane;
  assign access = wb_in.cyc && wb_in.stb && !ack_q;
  assign wr_lane = access && wb_in.we && wb_in.sel[0];
  assign stby_wr = wr_lane && (wb_in.adr == `STBY_CTRL_OFS); // see RULE20
  assign stby_mode = wb_in.dat[1:0];

  always_comb begin
    edge_zero_d = edge_zero_q;
    edge_one_d = edge_one_q;
    irq_cfg_d = irq_cfg_q;
    osc_d = osc_q;
    adc_d = adc_q;
    dac_d = dac_q;
    latch_d = latch_q;
    pmode_d = pmode_q;
    pctrl_d = pctrl_q;
    rdat_d = rdat_q;
    ack_d = access;
    if (wr_lane) begin
      case (wb_in.adr)
        `EDGE_ZERO_OFS: edge_zero_d = wb_in.dat[0];
        `EDGE_ONE_OFS: edge_one_d = wb_in.dat[1:0];
        `IRQ_CFG_OFS: irq_cfg_d = wb_in.dat[3:0];
        `OSC_SETTLE_OFS: osc_d = wb_in.dat[7:0];
        `ADC_MODE_OFS: adc_d = wb_in.dat[7:0];
        `DAC_MODE_OFS: dac_d = wb_in.dat[1:0];
        `PORT_LATCH_OFS: latch_d = wb_in.dat[7:0];
        `PORT_MODE_OFS: pmode_d = wb_in.dat[7:0];
        `PORT_CTRL_OFS: pctrl_d = wb_in.dat[7:0];
        default: ;
      endcase
    end
    if (access && !wb_in.we) begin
      case (wb_in.adr)
        `STBY_CTRL_OFS: rdat_d = {30'h0, standby_state_out};
        `EDGE_ZERO_OFS: rdat_d = {31'h0, edge_zero_q};
        `EDGE_ONE_OFS: rdat_d = {30'h0, edge_one_q};
        `IRQ_CFG_OFS: rdat_d = {28'h0, irq_cfg_q};
        `OSC_SETTLE_OFS: rdat_d = {24'h0, osc_q};
        `ADC_MODE_OFS: rdat_d = {24'h0, adc_q};
        `DAC_MODE_OFS: rdat_d = {30'h0, dac_q};
        `PORT_LATCH_OFS: rdat_d = {24'h0, latch_q};
        `PORT_MODE_OFS: rdat_d = {24'h0, pmode_q};
        `PORT_CTRL_OFS: rdat_d = {24'h0, pctrl_q};
        `STATUS_OFS: rdat_d = {27'h0, state_q, ext_pend_q, nmi_pend_q};
        default: rdat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      edge_zero_q <= 1'b0;
      edge_one_q <= 2'h0;
      irq_cfg_q <= `IRQ_CFG_RESET;
      osc_q <= 8'h00;
      adc_q <= 8'h00;
      dac_q <= `DAC_MODE_RESET;
      latch_q <= 8'h00;
      pmode_q <= `PORT_MODE_RESET;
      pctrl_q <= 8'h00;
      rdat_q <= 32'h0;
      ack_q <= 1'b0;
    end else begin
      edge_zero_q <= edge_zero_d;
      edge_one_q <= edge_one_d;
      irq_cfg_q <= irq_cfg_d;
      osc_q <= osc_d;
      adc_q <= adc_d;
      dac_q <= dac_d;
      latch_q <= latch_d;
      pmode_q <= pmode_d;
      pctrl_q <= pctrl_d;
      rdat_q <= rdat_d;
      ack_q <= ack_d;
    end
  end

  assign wb_dat_out = rdat_q;
  assign wb_ack_out = ack_q;

  // --------------------------------------------------------------------
  // Standby sequencer
  // --------------------------------------------------------------------
  state_t state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] mode_q, mode_d;
  logic nmi_pend_d, ext_pend_d;
  logic branch_nmi_q, branch_nmi_d;
  logic branch_ext_q, branch_ext_d;
  logic resume_q, resume_d;
  logic ext_ok_edge;
  logic wake;
  logic pend_cond;
  logic leave;

  // A masked or macro-serviced pin cannot wake or pend here.
  assign ext_ok_edge = (pin_edge[1] && !irq_cfg_q[`MASK_A_BIT] &&
                        !irq_cfg_q[`MACRO_A_BIT]) ||
                       (pin_edge[2] && !irq_cfg_q[`MASK_B_BIT] &&
                        !irq_cfg_q[`MACRO_B_BIT]); // see RULE4 see RULE21
  assign wake = pin_edge[0] || ext_ok_edge; // see RULE1 see RULE18
  assign pend_cond = nmi_pend_q || ext_pend_q || core_in.halt_release;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    mode_d = mode_q;
    leave = 1'b0;
    // Set wins over the core's acknowledgement in the same cycle.
    nmi_pend_d = pin_edge[0] || (nmi_pend_q && !core_in.nmi_taken); // see RULE19
    ext_pend_d = ext_ok_edge || (ext_pend_q && !core_in.ext_taken); // see RULE19
    case (state_q)
      ST_RUN: begin
        if (stby_wr && stby_mode != `MODE_RUN) begin
          mode_d = stby_mode; // see RULE20
          if (pend_cond || wake) begin
            leave = 1'b1; // see RULE11
          end else begin
            state_d = ST_ENTER;
            cnt_d = 4'h0;
          end
        end
      end
      // The window lets a contending request win before the clocks stop.
      ST_ENTER: begin
        if (pend_cond || wake) begin
          state_d = ST_RUN; // see RULE15
          leave = 1'b1;
        end else if (cnt_q == 4'(CONT_CLKS - 1)) begin
          case (mode_q)
            `MODE_HALT: state_d = ST_HALT;
            `MODE_STOP: state_d = ST_STOP;
            default: state_d = ST_IDLE;
          endcase
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      ST_HALT: begin
        if (pend_cond || wake) begin
          state_d = ST_RUN;
          leave = 1'b1;
        end
      end
      ST_STOP, ST_IDLE: begin
        if (wake) begin
          state_d = ST_RUN; // see RULE1 see RULE4
          leave = 1'b1;
        end
      end
      default: state_d = ST_RUN;
    endcase
    branch_nmi_d = nmi_pend_d && core_in.nmi_ack_ok &&
                   (state_d == ST_RUN); // see RULE2 see RULE3
    branch_ext_d = ext_pend_d && core_in.irq_allow && core_in.ext_ack_ok &&
                   (state_d == ST_RUN) && !branch_nmi_d; // see RULE5
    resume_d = leave && !branch_nmi_d && !branch_ext_d; // see RULE3 see RULE5
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_RUN;
      cnt_q <= 4'h0;
      mode_q <= `MODE_RUN;
      nmi_pend_q <= 1'b0;
      ext_pend_q <= 1'b0;
      branch_nmi_q <= 1'b0;
      branch_ext_q <= 1'b0;
      resume_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      nmi_pend_q <= nmi_pend_d;
      ext_pend_q <= ext_pend_d;
      branch_nmi_q <= branch_nmi_d;
      branch_ext_q <= branch_ext_d;
      resume_q <= resume_d;
    end
  end

  assign branch_nmi_out = branch_nmi_q;
  assign branch_ext_out = branch_ext_q;
  assign resume_out = resume_q;

  // --------------------------------------------------------------------
  // Pin control
  // --------------------------------------------------------------------
  pin_ctrl_t pins_q, pins_d;
  logic [1:0] sstate_q, sstate_d;
  logic deep_d;

  always_comb begin
    deep_d = is_deep(state_d);
    case (state_d)
      ST_HALT: sstate_d = `MODE_HALT;
      ST_STOP: sstate_d = `MODE_STOP;
      ST_IDLE: sstate_d = `MODE_IDLE;
      default: sstate_d = `MODE_RUN;
    endcase
    pins_d.bus_oe = !deep_d; // see RULE6
    pins_d.ale_oe = !deep_d; // see RULE7
    pins_d.refresh_lvl = deep_d ? `REFRESH_FIXED_LEVEL :
                         core_in.refresh_hw; // see RULE7
    pins_d.refresh_oe = 1'b1;
    // Standby does not gate these; software must clear the bits itself.
    pins_d.ano_oe = dac_q; // see RULE8 see RULE9
    pins_d.dac_power = |dac_q; // see RULE9
    pins_d.ano_ref3 = (sstate_d != `MODE_RUN) ? dac_q : 2'h0; // see RULE10
    pins_d.adc_power = adc_q[`ADC_POWER_BIT];
    pins_d.osc_run = !osc_q[`EXT_CLK_SEL_BIT]; // see RULE12
    for (int i = 0; i < 8; i++) begin
      pins_d.port_lvl[i] = pctrl_q[i] ? core_in.port_hw_lvl[i] :
                           latch_q[i]; // see RULE17
      pins_d.port_oe[i] = pctrl_q[i] ? core_in.port_hw_oe[i] :
                          !pmode_q[i]; // see RULE17
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pins_q <= '0;
      sstate_q <= `MODE_RUN;
    end else begin
      pins_q <= pins_d;
      sstate_q <= sstate_d;
    end
  end

  assign pins_out = pins_q;
  assign standby_state_out = sstate_q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_nmi_wakes_idle: assert property ( // see RULE1
    @(posedge clk_in) disable iff (rst_in)
    (state_q == ST_IDLE && pin_edge[0]) |=> state_q == ST_RUN
  ) else $error("NMI edge did not end idle.");

  a_masked_stays: assert property ( // see RULE21
    @(posedge clk_in) disable iff (rst_in)
    (state_q == ST_IDLE && !pin_edge[0] && !ext_ok_edge)
      |=> state_q == ST_IDLE
  ) else $error("Idle left without an allowed source.");

  a_nmi_branch: assert property ( // see RULE2
    @(posedge clk_in) disable iff (rst_in)
    (state_q == ST_IDLE && pin_edge[0] && core_in.nmi_ack_ok)
      |=> branch_nmi_out && !resume_out
  ) else $error("NMI wake did not branch.");

  a_nmi_held: assert property ( // see RULE3
    @(posedge clk_in) disable iff (rst_in)
    (nmi_pend_q && !core_in.nmi_taken) |=> nmi_pend_q
  ) else $error("Pending NMI lost.");

  a_ext_no_allow: assert property ( // see RULE5
    @(posedge clk_in) disable iff (rst_in)
    !core_in.irq_allow |=> !branch_ext_out
  ) else $error("Pin branch without global enable.");

  a_bus_float: assert property ( // see RULE6
    @(posedge clk_in) disable iff (rst_in)
    (state_q == ST_IDLE) |-> (!pins_out.bus_oe && !pins_out.ale_oe)
  ) else $error("Bus driven in idle.");

  a_refuse_entry: assert property ( // see RULE11
    @(posedge clk_in) disable iff (rst_in)
    (state_q == ST_RUN && stby_wr && core_in.halt_release)
      |=> state_q == ST_RUN ##1 state_q == ST_RUN
  ) else $error("Standby entered with release pending.");

  a_entry_window: assert property ( // see RULE15
    @(posedge clk_in) disable iff (rst_in)
    $rose(state_q == ST_ENTER) |-> ##[1:CONT_CLKS] state_q != ST_ENTER
  ) else $error("Entry window overran.");

  a_dac_float: assert property ( // see RULE9
    @(posedge clk_in) disable iff (rst_in)
    (dac_q == 2'h0) |=> (pins_out.ano_oe == 2'h0 && !pins_out.dac_power)
  ) else $error("Analog outputs driven with channels off.");

  a_osc_stop: assert property ( // see RULE12
    @(posedge clk_in) disable iff (rst_in)
    osc_q[`EXT_CLK_SEL_BIT] |=> !pins_out.osc_run
  ) else $error("Oscillator kept running.");

endmodule

// ===== tb/core_partner.sv
module core_partner
  import idle_standby_pkg::*;
#(
  parameter int TAKE_DLY = 3
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic nmi_ok_in,
  input wire logic ext_ok_in,
  input wire logic allow_in,
  input wire logic halt_in,
  input wire logic branch_nmi_in,
  input wire logic branch_ext_in,
  output core_status_t core_out
);
  // ----------------------------------------------------------------------
  // Core acknowledge
  // ----------------------------------------------------------------------
  // The core takes a shown branch only after TAKE_DLY cycles, so a design
  // that drops its branch request early is caught by the missing count.
  logic [3:0] nmi_wait_q;
  logic [3:0] ext_wait_q;
  logic nmi_take_q;
  logic ext_take_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nmi_wait_q <= 4'h0;
      ext_wait_q <= 4'h0;
      nmi_take_q <= 1'b0;
      ext_take_q <= 1'b0;
    end else begin
      nmi_take_q <= branch_nmi_in && (nmi_wait_q == 4'(TAKE_DLY));
      ext_take_q <= branch_ext_in && (ext_wait_q == 4'(TAKE_DLY));
      nmi_wait_q <= (branch_nmi_in && nmi_wait_q != 4'(TAKE_DLY)) ?
        nmi_wait_q + 4'h1 : 4'h0;
      ext_wait_q <= (branch_ext_in && ext_wait_q != 4'(TAKE_DLY)) ?
        ext_wait_q + 4'h1 : 4'h0;
    end
  end

  assign core_out = '{nmi_ack_ok: nmi_ok_in, ext_ack_ok: ext_ok_in,
    irq_allow: allow_in, nmi_taken: nmi_take_q, ext_taken: ext_take_q,
    halt_release: halt_in, refresh_hw: 1'b0, port_hw_lvl: 8'hA5,
    port_hw_oe: 8'hFF};
endmodule

// ===== tb/tb_idle_standby_wakeup.sv
`include "idle_standby_defines.svh"
module tb_idle_standby_wakeup
  import idle_standby_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_in, wb_ack_out, resume_out;
  logic branch_nmi_out, branch_ext_out, prev_n, prev_e;
  logic nmi_ok, ext_ok, allow, halt;
  logic [2:0] irq_pins;
  logic [1:0] standby_state_out;
  logic [31:0] wb_dat_out, rd;
  wb_req_t wb_in;
  core_status_t core_in;
  pin_ctrl_t pins_out;
  int err_total = 0, n_checks = 0, cycles = 0;
  int n_nmi = 0, n_ext = 0, n_res = 0, sn, se, sr;

  idle_standby_wakeup uut (.clk_in(clk_in), .rst_in(rst_in), .wb_in(wb_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .nmi_pin_in(irq_pins[0]), .ext_irq_pin_a_in(irq_pins[1]),
    .ext_irq_pin_b_in(irq_pins[2]), .core_in(core_in),
    .standby_state_out(standby_state_out), .branch_nmi_out(branch_nmi_out),
    .branch_ext_out(branch_ext_out), .resume_out(resume_out),
    .pins_out(pins_out));
  core_partner partner (.clk_in(clk_in), .rst_in(rst_in), .nmi_ok_in(nmi_ok),
    .ext_ok_in(ext_ok), .allow_in(allow), .halt_in(halt),
    .branch_nmi_in(branch_nmi_out), .branch_ext_in(branch_ext_out),
    .core_out(core_in));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------------
  // Event counters and timeout
  // ----------------------------------------------------------------------
  // Pulses are counted here so no scenario has to hit their exact cycle.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (resume_out === 1'b1) n_res <= n_res + 1;
    if (branch_nmi_out === 1'b1 && prev_n !== 1'b1) n_nmi <= n_nmi + 1;
    if (branch_ext_out === 1'b1 && prev_e !== 1'b1) n_ext <= n_ext + 1;
    prev_n <= branch_nmi_out;
    prev_e <= branch_ext_out;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  task results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_in);
    wb_in <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    rd = wb_dat_out;
    wb_in <= '0;
    // Registered pin outputs follow a write one edge after the ack edge.
    @(posedge clk_in);
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  task wait_state(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (standby_state_out !== s && n < 60);
    repeat (2) @(posedge clk_in);
    chk(standby_state_out, s);
  endtask

  task pulse(input logic [2:0] v);
    @(posedge clk_in);
    irq_pins <= v;
    repeat (5) @(posedge clk_in);
    irq_pins <= 3'h0;
    repeat (5) @(posedge clk_in);
  endtask

  task snap();
    sn = n_nmi;
    se = n_ext;
    sr = n_res;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    wb_in = '0;
    irq_pins = 3'h0;
    {nmi_ok, ext_ok, allow, halt} = 4'hE;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({pins_out.bus_oe, pins_out.ale_oe, pins_out.refresh_oe,
      pins_out.osc_run, pins_out.dac_power, pins_out.ano_oe}, 32'h7F);
    bus(1'b0, `IRQ_CFG_OFS, 32'h0);
    chk(rd, 32'(`IRQ_CFG_RESET));
    bus(1'b0, `DAC_MODE_OFS, 32'h0);
    chk(rd, 32'(`DAC_MODE_RESET));
    bus(1'b0, `PORT_MODE_OFS, 32'h0);
    chk(rd, 32'(`PORT_MODE_RESET));
    bus(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `EDGE_ZERO_OFS, 32'h1);
    bus(1'b1, `EDGE_ONE_OFS, 32'h3);
    bus(1'b1, `DAC_MODE_OFS, 32'h1);
    chk({pins_out.ano_oe, pins_out.dac_power}, 32'h3);
    bus(1'b1, `DAC_MODE_OFS, 32'h0);
    chk({pins_out.ano_oe, pins_out.dac_power}, 32'h0);
    bus(1'b1, `DAC_MODE_OFS, 32'h3);
    bus(1'b1, `OSC_SETTLE_OFS, 32'h1);
    chk(pins_out.osc_run, 32'h0);
    bus(1'b1, `OSC_SETTLE_OFS, 32'h0);
    bus(1'b1, `ADC_MODE_OFS, 32'h80);
    chk(pins_out.adc_power, 32'h1);
    bus(1'b1, `ADC_MODE_OFS, 32'h0);
    chk(pins_out.adc_power, 32'h0);
    bus(1'b1, `PORT_LATCH_OFS, 32'h3C);
    bus(1'b1, `PORT_MODE_OFS, 32'h01);
    bus(1'b1, `PORT_CTRL_OFS, 32'hC0);
    repeat (2) @(posedge clk_in);
    chk(pins_out.port_lvl, 32'hBC);
    chk(pins_out.port_oe, 32'hFE);
    // Wake by the non-maskable pin while the core can take it.
    snap();
    bus(1'b1, `STBY_CTRL_OFS, 32'h3);
    repeat (3) @(posedge clk_in);
    wait_state(`MODE_IDLE);
    chk({pins_out.bus_oe, pins_out.ale_oe, pins_out.refresh_lvl,
      pins_out.refresh_oe}, 32'h3);
    chk({pins_out.ano_oe, pins_out.ano_ref3}, 32'hF);
    pulse(3'h1);
    wait_state(`MODE_RUN);
    chk(n_nmi - sn, 32'h1);
    chk(pins_out.bus_oe, 32'h1);
    // Same wake while the core cannot take it yet.
    nmi_ok <= 1'b0;
    snap();
    bus(1'b1, `STBY_CTRL_OFS, 32'h3);
    wait_state(`MODE_IDLE);
    pulse(3'h1);
    wait_state(`MODE_RUN);
    chk(n_res - sr, 32'h1);
    chk(n_nmi - sn, 32'h0);
    bus(1'b0, `STATUS_OFS, 32'h0);
    chk(rd[0], 32'h1);
    nmi_ok <= 1'b1;
    repeat (12) @(posedge clk_in);
    chk(n_nmi - sn, 32'h1);
    bus(1'b0, `STATUS_OFS, 32'h0);
    chk(rd[0], 32'h0);
    // Masked and macro-serviced pins must not wake; then a clean pin wake.
    snap();
    bus(1'b1, `STBY_CTRL_OFS, 32'h3);
    wait_state(`MODE_IDLE);
    pulse(3'h6);
    chk(standby_state_out, 32'h3);
    bus(1'b1, `IRQ_CFG_OFS, 32'hC);
    pulse(3'h6);
    chk(standby_state_out, 32'h3);
    bus(1'b1, `IRQ_CFG_OFS, 32'h0);
    pulse(3'h2);
    wait_state(`MODE_RUN);
    repeat (8) @(posedge clk_in);
    chk(n_ext - se, 32'h1);
    // A pending halt release refuses entry altogether.
    halt <= 1'b1;
    snap();
    bus(1'b1, `STBY_CTRL_OFS, 32'h3);
    repeat (12) @(posedge clk_in);
    chk(standby_state_out, 32'h0);
    chk(n_res - sr, 32'h1);
    halt <= 1'b0;
    // Stop mode left by pin b with the global flag clear resumes in line.
    allow <= 1'b0;
    snap();
    bus(1'b1, `STBY_CTRL_OFS, 32'h2);
    wait_state(`MODE_STOP);
    chk({pins_out.bus_oe, pins_out.ale_oe}, 32'h0);
    pulse(3'h4);
    wait_state(`MODE_RUN);
    chk(n_res - sr, 32'h1);
    chk(n_ext - se, 32'h0);
    allow <= 1'b1;
    repeat (12) @(posedge clk_in);
    chk(n_ext - se, 32'h1);
    // Halt keeps the bus driven and is left by a core release condition.
    snap();
    bus(1'b1, `STBY_CTRL_OFS, 32'h1);
    wait_state(`MODE_HALT);
    chk(pins_out.bus_oe, 32'h1);
    halt <= 1'b1;
    wait_state(`MODE_RUN);
    chk(n_res - sr, 32'h1);
    halt <= 1'b0;
    results();
  end
endmodule
